//--- hdl/irq_regs_pkg.sv
// Overview of operation
// - enable/timer flag bits 7,6 read zero
// - listed reserved low bits always read one
// - timer overflow enable gates timer request
// - a set in the clear cycle wins and the request still reaches cpu
// - direct transition sets flag when enabled
// - rtc overflow sets rtc flag
// - selected pin edge sets pin flag
// - timer overflow sets timer flag
// - edge select zero falling, one rising
package irq_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the apb
  localparam logic [11:0] timer_irq_enable_offset = 12'h000;
  localparam logic [11:0] irq_flags_one_offset    = 12'h004;
  localparam logic [11:0] timer_irq_flags_offset  = 12'h008;
  localparam logic [11:0] pin_config_offset       = 12'h00c;
  localparam logic [11:0] irq_status_offset       = 12'h010;
  localparam logic [11:0] irq_mask_offset         = 12'h014;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int reg_width  = 8;
  localparam int pin_count  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions in the register layouts
  localparam int direct_transition_bit = 7;
  localparam int rtc_overflow_bit      = 6;
  localparam int timer_overflow_bit    = 5;
  localparam int pin_mode_lsb          = 4;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] flags_reset      = 8'h00;
  localparam logic [7:0] pin_config_reset = 8'h00;
  localparam logic [7:0] mask_reset       = 8'h00;
  localparam logic       enable_reset     = 1'b0;
  localparam logic [7:0] prdata_reset     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // reserved read patterns
  localparam logic [4:0] timer_low_ones = 5'h1f;
  localparam logic [1:0] timer_high_zeros = 2'h0;
  localparam logic [1:0] flags_one_mid_ones = 2'h3;
  // bits that hold a real flag in the merged flag layout
  localparam logic [7:0] flag_live_bits = 8'hef;

  ////////////////////////////////////////////////////////////////////////////
  // apb transfer phase
  typedef enum logic [1:0]
  {
    bus_idle   = 2'b00,
    bus_setup  = 2'b01,
    bus_access = 2'b10
  } bus_phase_type;

endpackage

//--- hdl/flag_bank_if.sv
`timescale 1ns/1ps
// carries set and clear vectors into a sticky bank and its value back
interface flag_bank_if;
  logic [7:0] set;    // hardware events, one-cycle pulses
  logic [7:0] clr;    // software clear strobes
  logic [7:0] q;      // current flag values

  modport ctrl
  (
    output set,
    output clr,
    input  q
  );

  modport bank
  (
    input  set,
    input  clr,
    output q
  );
endinterface

//--- hdl/sticky_bank.sv
`timescale 1ns/1ps
// bank of sticky flags; a set in the clear cycle wins
module sticky_bank
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // set, clear and value
  flag_bank_if.bank fb
);
  import irq_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // flags hold until cleared; set beats clear, a write of one sets nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fb.q <= flags_reset;
    end
    else
    begin
      fb.q <= (fb.q & ~fb.clr) | fb.set;
    end
  end
endmodule

//--- hdl/pin_edge_detect.sv
`timescale 1ns/1ps
// synchronises one external pin and flags the selected edge
module pin_edge_detect
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and selection
  input  wire logic pin,
  input  wire logic rising_sel,
  // detected edge, one cycle
  output logic      edge_pulse
);
  import irq_regs_pkg::*;

  logic sync_first;   // first synchroniser stage
  logic sync_second;  // second synchroniser stage
  logic prev;         // last synchronised level

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser plus history flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
      prev        <= 1'b1;
    end
    else
    begin
      sync_first  <= pin;
      sync_second <= sync_first;
      prev        <= sync_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero picks falling edges, one picks rising edges
  always_comb
  begin
    if (rising_sel)
    begin
      edge_pulse = sync_second & ~prev;
    end
    else
    begin
      edge_pulse = ~sync_second & prev;
    end
  end
endmodule

//--- hdl/irq_enable_flag_regs.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// interrupt enable and request flag registers behind an apb slave
module irq_enable_flag_regs
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external interrupt pins, asynchronous
  input  wire logic [irq_regs_pkg::pin_count-1:0] ext_pin,
  // request sources on pclk
  input  wire logic        rtc_overflow,
  input  wire logic        timer_overflow,
  input  wire logic        direct_transition_event,
  input  wire logic        direct_transition_on,
  // enables held outside this slice
  input  wire logic [7:0]  enable_one,
  // requests toward the cpu
  output logic             direct_transition_req,
  output logic             rtc_overflow_req,
  output logic [irq_regs_pkg::pin_count-1:0] ext_pin_req,
  output logic             timer_overflow_req,
  // summary interrupt
  output logic             irq
);
  import irq_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  bus_phase_type bus_phase;               // current apb phase
  logic          timer_overflow_irq_en;   // timer overflow enable bit
  logic [7:0]    pin_config;              // edge selects and pin modes
  logic [7:0]    irq_mask;                // summary interrupt mask
  logic [7:0]    read_value;              // selected register value
  logic          addr_hit;                // address is mapped
  logic          setup_cycle;             // first cycle of a transfer
  logic          write_take;              // write takes effect now
  logic [pin_count-1:0] pin_edge;         // detected edges per pin
  logic [pin_count-1:0] ext_pin_edge_select; // edge select per pin
  logic [pin_count-1:0] pin_is_irq;       // pin used as interrupt input
  logic [7:0]    flag_set;                // hardware set vector
  logic [7:0]    flag_clr;                // software clear for flags
  logic [7:0]    status_clr;              // software clear for status
  logic [7:0]    wbyte;                   // low byte of write data
  logic          direct_transition_flag;  // merged flag aliases
  logic          rtc_overflow_flag;
  logic          timer_overflow_flag;
  logic [pin_count-1:0] ext_pin_flag;

  flag_bank_if flags_if ();               // request flag bank
  flag_bank_if status_if ();              // summary status bank

  assign wbyte               = pwdata[7:0];
  assign ext_pin_edge_select = pin_config[pin_count-1:0];
  assign pin_is_irq          = pin_config[pin_mode_lsb+pin_count-1:
                                          pin_mode_lsb];

  ////////////////////////////////////////////////////////////////////////////
  // apb phase tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_phase <= bus_idle;
    end
    else
    begin
      unique case (bus_phase)
        bus_idle:
        begin
          // a selected bus waits for its setup cycle
          if (psel && !penable)
          begin
            bus_phase <= bus_setup;
          end
        end
        bus_setup:
        begin
          // zero wait states: access always follows
          bus_phase <= bus_access;
        end
        bus_access:
        begin
          // back-to-back setup or idle
          if (psel && !penable)
          begin
            bus_phase <= bus_setup;
          end
          else
          begin
            bus_phase <= bus_idle;
          end
        end
        default:
        begin
          bus_phase <= bus_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode and strobes
  assign setup_cycle = psel & ~penable;
  // bus_setup marks the access cycle that follows a proper setup cycle
  assign write_take  = psel & penable & pwrite & addr_hit &
                       (bus_phase == bus_setup);
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~addr_hit;

  always_comb
  begin
    unique case (paddr)
      timer_irq_enable_offset,
      irq_flags_one_offset,
      timer_irq_flags_offset,
      pin_config_offset,
      irq_status_offset,
      irq_mask_offset:
      begin
        addr_hit = 1'b1;
      end
      default:
      begin
        // unmapped word answers with an error
        addr_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag aliases out of the merged layout
  assign direct_transition_flag = flags_if.q[direct_transition_bit];
  assign rtc_overflow_flag      = flags_if.q[rtc_overflow_bit];
  assign timer_overflow_flag    = flags_if.q[timer_overflow_bit];
  assign ext_pin_flag           = flags_if.q[pin_count-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // read value with reserved bits forced
  always_comb
  begin
    read_value = 8'h00;
    unique case (paddr)
      timer_irq_enable_offset:
      begin
        read_value = {timer_high_zeros, timer_overflow_irq_en,
                      timer_low_ones};
      end
      irq_flags_one_offset:
      begin
        read_value = {direct_transition_flag, rtc_overflow_flag,
                      flags_one_mid_ones, ext_pin_flag};
      end
      timer_irq_flags_offset:
      begin
        read_value = {timer_high_zeros, timer_overflow_flag,
                      timer_low_ones};
      end
      pin_config_offset:
      begin
        read_value = pin_config;
      end
      irq_status_offset:
      begin
        read_value = status_if.q;
      end
      irq_mask_offset:
      begin
        read_value = irq_mask;
      end
      default:
      begin
        // unmapped reads return zero
        read_value = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data registered in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= {24'h000000, prdata_reset};
    end
    else if (setup_cycle && !pwrite)
    begin
      prdata <= {24'h000000, read_value};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer overflow enable; reserved bits are not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_overflow_irq_en <= enable_reset;
    end
    else if (write_take && paddr == timer_irq_enable_offset)
    begin
      timer_overflow_irq_en <= wbyte[timer_overflow_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin configuration: edge selects and interrupt-input modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_config <= pin_config_reset;
    end
    else if (write_take && paddr == pin_config_offset)
    begin
      pin_config <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= mask_reset;
    end
    else if (write_take && paddr == irq_mask_offset)
    begin
      irq_mask <= wbyte & flag_live_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detectors, one per external pin
  for (genvar i = 0; i < pin_count; i++)
  begin : g_pin
    pin_edge_detect u_edge
    (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin        (ext_pin[i]),
      .rising_sel (ext_pin_edge_select[i]),
      .edge_pulse (pin_edge[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // hardware set events in the merged layout
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[direct_transition_bit] = direct_transition_event &
                                      direct_transition_on;
    flag_set[rtc_overflow_bit]      = rtc_overflow;
    flag_set[timer_overflow_bit]    = timer_overflow;
    flag_set[pin_count-1:0]         = pin_edge & pin_is_irq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // writing zero clears a flag; writing one leaves it
  always_comb
  begin
    flag_clr = 8'h00;
    if (write_take && paddr == irq_flags_one_offset)
    begin
      flag_clr[direct_transition_bit] = ~wbyte[direct_transition_bit];
      flag_clr[rtc_overflow_bit]      = ~wbyte[rtc_overflow_bit];
      flag_clr[pin_count-1:0]         = ~wbyte[pin_count-1:0];
    end
    else if (write_take && paddr == timer_irq_flags_offset)
    begin
      flag_clr[timer_overflow_bit] = ~wbyte[timer_overflow_bit];
    end
  end

  // status bits clear on a written one
  always_comb
  begin
    status_clr = 8'h00;
    if (write_take && paddr == irq_status_offset)
    begin
      status_clr = wbyte & flag_live_bits;
    end
  end

  assign flags_if.set  = flag_set;
  assign flags_if.clr  = flag_clr;
  assign status_if.set = flag_set;
  assign status_if.clr = status_clr;

  ////////////////////////////////////////////////////////////////////////////
  // flag storage
  sticky_bank u_flags
  (
    .pclk    (pclk),
    .presetn (presetn),
    .fb      (flags_if.bank)
  );

  sticky_bank u_status
  (
    .pclk    (pclk),
    .presetn (presetn),
    .fb      (status_if.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // requests to the cpu come from stored flags; a set in the same cycle
  // as a clear wins, so the flag stays and the request is still
  // presented; software is expected to clear while masked
  assign direct_transition_req = direct_transition_flag &
                                 enable_one[direct_transition_bit];
  assign rtc_overflow_req      = rtc_overflow_flag &
                                 enable_one[rtc_overflow_bit];
  assign ext_pin_req           = ext_pin_flag &
                                 enable_one[pin_count-1:0];
  assign timer_overflow_req    = timer_overflow_flag &
                                 timer_overflow_irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // summary interrupt, a level while any unmasked status bit is set
  assign irq = |(status_if.q & irq_mask);

endmodule

//--- verif/irq_regs_asserts.sv
`timescale 1ns/1ps
// watches the register slice at its ports
module irq_regs_asserts
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // sources and enables
  input wire logic        rtc_overflow,
  input wire logic        direct_transition_event,
  input wire logic        direct_transition_on,
  input wire logic [7:0]  enable_one,
  // requests toward the cpu
  input wire logic        direct_transition_req,
  input wire logic        rtc_overflow_req,
  input wire logic [irq_regs_pkg::pin_count-1:0] ext_pin_req
);
  import irq_regs_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // access phase of a read at one offset
  sequence s_read(logic [11:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  // access phase of a write at one offset
  sequence s_write(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_enable_top_zero: assert property (
    s_read(timer_irq_enable_offset) |-> prdata[31:6] == 26'h0)
    else $error("timer enable top bits not zero");
  a_enable_low_ones: assert property (
    s_read(timer_irq_enable_offset) |-> prdata[4:0] == 5'h1f)
    else $error("timer enable low bits not one");
  a_flags_mid_ones: assert property (
    s_read(irq_flags_one_offset) |-> prdata[5:4] == 2'h3)
    else $error("first flag register mid bits not one");
  a_timer_flag_fixed: assert property (
    s_read(timer_irq_flags_offset) |-> {prdata[7:6], prdata[4:0]} == 7'h1f)
    else $error("timer flag reserved bits wrong");
  a_rtc_clear_lands: assert property (
    s_write(irq_flags_one_offset) ##0 (!pwdata[6] && !rtc_overflow)
    |=> !rtc_overflow_req)
    else $error("rtc request stayed after clear");
  a_rtc_sets_req: assert property (
    rtc_overflow && enable_one[6] ##1 enable_one[6] |-> rtc_overflow_req)
    else $error("rtc overflow did not raise request");
  a_dt_sets_req: assert property (
    direct_transition_event && direct_transition_on && enable_one[7]
    ##1 enable_one[7] |-> direct_transition_req)
    else $error("direct transition did not raise request");
  a_dt_only_hw: assert property (
    $rose(direct_transition_req) |-> $rose(enable_one[7]) ||
    ($past(direct_transition_event) && $past(direct_transition_on)))
    else $error("direct transition request without event");
  a_rtc_only_hw: assert property (
    $rose(rtc_overflow_req) |-> $past(rtc_overflow) || $rose(enable_one[6]))
    else $error("rtc request without event");
  a_req_gated: assert property (
    (ext_pin_req & ~enable_one[pin_count-1:0]) == 4'h0 &&
    !(rtc_overflow_req && !enable_one[6]) &&
    !(direct_transition_req && !enable_one[7]))
    else $error("request present with enable low");
endmodule

bind irq_enable_flag_regs irq_regs_asserts u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .rtc_overflow(rtc_overflow),
  .direct_transition_event(direct_transition_event),
  .direct_transition_on(direct_transition_on), .enable_one(enable_one),
  .direct_transition_req(direct_transition_req),
  .rtc_overflow_req(rtc_overflow_req), .ext_pin_req(ext_pin_req)
);

//--- verif/irq_source_model.sv
`timescale 1ns/1ps
// request sources: timer, rtc, sleep logic and four pins
module irq_source_model
(
  // clock
  input  wire logic pclk,
  // one-cycle events on pclk
  output logic      rtc_overflow,
  output logic      timer_overflow,
  output logic      direct_transition_event,
  // pin levels, idle high
  output logic [irq_regs_pkg::pin_count-1:0] ext_pin
);
  import irq_regs_pkg::*;

  // quiet sources, pins idle high
  initial
  begin
    rtc_overflow = 1'b0;
    timer_overflow = 1'b0;
    direct_transition_event = 1'b0;
    ext_pin = 4'hf;
  end

  // one-cycle pulse on chosen sources; bit0 rtc, bit1 timer, bit2 sleep
  task automatic pulse(input logic [2:0] src);
    rtc_overflow <= src[0];
    timer_overflow <= src[1];
    direct_transition_event <= src[2];
    @(posedge pclk);
    rtc_overflow <= 1'b0;
    timer_overflow <= 1'b0;
    direct_transition_event <= 1'b0;
  endtask

  // new pin levels, held long enough to clear the synchroniser
  task automatic pins(input logic [3:0] lvl);
    ext_pin <= lvl;
    repeat (6) @(posedge pclk);
  endtask
endmodule

//--- verif/irq_enable_flag_regs_tb.sv
`timescale 1ns/1ps
// drives the register slice over apb and checks what it reports
module irq_enable_flag_regs_tb;
  import irq_regs_pkg::*;

`define check(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("CHECK FAILED at %0t: got %h, expected %h", \
  $time, got, exp); end end

  ////////////////////////////////////////////////////////////////////////////
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0]  ext_pin, ext_pin_req;
  logic [7:0]  enable_one;
  logic        rtc_overflow, timer_overflow, direct_transition_event;
  logic        direct_transition_on, direct_transition_req;
  logic        rtc_overflow_req, timer_overflow_req, rd_err;
  int          n_mismatch, checks_done;

  irq_enable_flag_regs dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
    .rtc_overflow(rtc_overflow), .timer_overflow(timer_overflow),
    .direct_transition_event(direct_transition_event),
    .direct_transition_on(direct_transition_on), .enable_one(enable_one),
    .direct_transition_req(direct_transition_req),
    .rtc_overflow_req(rtc_overflow_req), .ext_pin_req(ext_pin_req),
    .timer_overflow_req(timer_overflow_req), .irq(irq)
  );

  irq_source_model src
  (
    .pclk(pclk), .rtc_overflow(rtc_overflow),
    .timer_overflow(timer_overflow),
    .direct_transition_event(direct_transition_event), .ext_pin(ext_pin)
  );

  // free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer: setup cycle, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {{24{w}}, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read one register and compare the whole word
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    `check({rd_err, rd_data}, {1'b0, exp})
  endtask

  // reset values, fixed bits, and an unmapped place
  task automatic t_reset_regs();
    rd(timer_irq_enable_offset, 32'h1f);
    rd(irq_flags_one_offset, 32'h30);
    rd(timer_irq_flags_offset, 32'h1f);
    apb(1'b1, timer_irq_enable_offset, 8'hff);
    rd(timer_irq_enable_offset, 32'h3f);
    apb(1'b1, timer_irq_flags_offset, 8'hff);
    rd(timer_irq_flags_offset, 32'h1f);
    apb(1'b0, 12'hffc, 8'h00);
    `check({rd_err, rd_data}, {1'b1, 32'h0})
  endtask

  // timer overflow: flag, request, summary interrupt, enable drop
  task automatic t_timer();
    src.pulse(3'b010);
    rd(timer_irq_flags_offset, 32'h3f);
    `check(timer_overflow_req, 1'b1)
    `check(irq, 1'b0)
    apb(1'b1, irq_mask_offset, 8'h20);
    rd(irq_status_offset, 32'h20);
    `check(irq, 1'b1)
    apb(1'b1, timer_irq_flags_offset, 8'h00);
    rd(timer_irq_flags_offset, 32'h1f);
    `check(timer_overflow_req, 1'b0)
    apb(1'b1, irq_status_offset, 8'h20);
    rd(irq_status_offset, 32'h00);
    `check(irq, 1'b0)
    src.pulse(3'b010);
    apb(1'b1, timer_irq_enable_offset, 8'h00);
    rd(timer_irq_flags_offset, 32'h3f);
    `check(timer_overflow_req, 1'b0)
    apb(1'b1, timer_irq_flags_offset, 8'h00);
  endtask

  // sleep and rtc flags, and a clear that meets an event
  task automatic t_sources();
    @(posedge pclk);
    enable_one <= 8'hcf;
    src.pulse(3'b100);
    rd(irq_flags_one_offset, 32'h30);
    direct_transition_on <= 1'b1;
    src.pulse(3'b101);
    rd(irq_flags_one_offset, 32'hf0);
    `check({direct_transition_req, rtc_overflow_req}, 2'b11)
    apb(1'b1, irq_flags_one_offset, 8'hc0);
    rd(irq_flags_one_offset, 32'hf0);
    fork
      apb(1'b1, irq_flags_one_offset, 8'h00);
      begin
        repeat (2) @(posedge pclk);
        src.pulse(3'b001);
      end
    join
    rd(irq_flags_one_offset, 32'h70);
    `check(rtc_overflow_req, 1'b1)
    apb(1'b1, irq_flags_one_offset, 8'h00);
    rd(irq_flags_one_offset, 32'h30);
    // sleep gate off: no flag; rtc enable off: flag set but no request
    direct_transition_on <= 1'b0;
    enable_one <= 8'h8f;
    src.pulse(3'b101);
    rd(irq_flags_one_offset, 32'h70);
    `check({direct_transition_req, rtc_overflow_req}, 2'b00)
    apb(1'b1, irq_flags_one_offset, 8'h00);
  endtask

  // pin edges: unused pins ignored, edge select per pin
  task automatic t_pins();
    apb(1'b1, pin_config_offset, 8'h05);
    src.pins(4'h0);
    rd(irq_flags_one_offset, 32'h30);
    apb(1'b1, pin_config_offset, 8'hf5);
    src.pins(4'hf);
    rd(irq_flags_one_offset, 32'h35);
    src.pins(4'h0);
    rd(irq_flags_one_offset, 32'h3f);
    `check(ext_pin_req, 4'hf)
    // dropping some pin enables hides those requests only
    enable_one <= 8'h0a;
    rd(irq_flags_one_offset, 32'h3f);
    `check(ext_pin_req, 4'ha)
    apb(1'b1, irq_flags_one_offset, 8'h30);
    rd(irq_flags_one_offset, 32'h30);
  endtask

  // reset in mid-run returns enable, flags and requests to zero
  task automatic t_mid_reset();
    apb(1'b1, timer_irq_enable_offset, 8'h20);
    src.pulse(3'b011);
    rd(timer_irq_flags_offset, 32'h3f);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(timer_irq_enable_offset, 32'h1f);
    rd(timer_irq_flags_offset, 32'h1f);
    rd(irq_flags_one_offset, 32'h30);
    `check({timer_overflow_req, rtc_overflow_req, irq}, 3'b000)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // counts, verdict and end of run
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    enable_one = 8'h00;
    direct_transition_on = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_timer();
    t_sources();
    t_pins();
    t_mid_reset();
    results();
  end

  // hang guard, well beyond the roughly 150 cycles of the run
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    results();
  end
endmodule
